/* rtl/asp_pkg.sv */
package asp_pkg;

  // clock figures in kHz
  localparam int unsigned MCLK_KHZ     = 125_000;
  localparam int unsigned BCLK_I2S_KHZ = 12_288;
  localparam int unsigned BCLK_TDM_KHZ = 24_576;
  // shortest legal bit clock period in device clocks, rounded down
  localparam logic [7:0]  I2S_MIN_CYC  = 8'(MCLK_KHZ / BCLK_I2S_KHZ);
  localparam logic [7:0]  TDM_MIN_CYC  = 8'(MCLK_KHZ / BCLK_TDM_KHZ);
  localparam logic [7:0]  PER_SAT      = 8'hff;

  // register offsets
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_FRAME    = 8'h04;
  localparam logic [7:0]  ADR_TXMASK   = 8'h08;
  localparam logic [7:0]  ADR_RXMASK   = 8'h0c;
  localparam logic [7:0]  ADR_STATUS   = 8'h10;

  // status bit positions
  localparam int          ST_UDR       = 0;
  localparam int          ST_OVR       = 1;
  localparam int          ST_RATE      = 2;
  localparam int          ST_RUN       = 3;

  typedef enum logic [2:0] {
    FMT_I2S   = 3'h0,
    FMT_LJ    = 3'h1,
    FMT_RJ    = 3'h2,
    FMT_DSP   = 3'h3,
    FMT_PCM_S = 3'h4,
    FMT_PCM_L = 3'h5,
    FMT_TDM   = 3'h6
  } asp_fmt_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_HUNT = 2'b01,
    L_RUN  = 2'b11
  } asp_lstate_t;

  typedef struct packed {
    asp_fmt_t   fmt;
    logic       hiz;
    logic       fdx;
    logic       rx_en;
    logic       tx_en;
    logic       init;
    logic       en;
  } asp_ctrl_t;

  typedef struct packed {
    logic [4:0] word_last;
    logic [4:0] last_bit;
    logic [3:0] last_slot;
  } asp_frame_t;

  typedef struct packed {
    logic [3:0] slot;
    logic [4:0] bitn;
  } asp_pos_t;

  localparam asp_ctrl_t  CTRL_RST  = asp_ctrl_t'(9'h000);
  localparam asp_frame_t FRAME_RST = asp_frame_t'(14'h2ff1);
  localparam logic [15:0] MASK_RST = 16'h0003;
  localparam asp_pos_t   POS_ZERO  = asp_pos_t'(9'h000);

  // one bit later in the frame, wrapping slot and frame
  function automatic asp_pos_t pos_adv(asp_pos_t q, asp_frame_t f);
    asp_pos_t n;
    n = q;
    if (q.bitn == f.last_bit) begin
      n.bitn = 5'h00;
      n.slot = (q.slot == f.last_slot) ? 4'h0 : 4'(q.slot + 4'h1);
    end else begin
      n.bitn = 5'(q.bitn + 5'h01);
    end
    return n;
  endfunction

  // formats whose data lag the frame sync by one bit
  function automatic logic is_delayed(asp_fmt_t f);
    return (f == FMT_I2S) || (f == FMT_DSP) || (f == FMT_PCM_S) || (f == FMT_TDM);
  endfunction

  function automatic logic is_i2s(asp_fmt_t f);
    return (f == FMT_I2S) || (f == FMT_LJ) || (f == FMT_RJ);
  endfunction

  // frame sync level for the bit at position q
  function automatic logic fs_level(asp_fmt_t f, asp_pos_t q);
    logic v;
    case (f)
      FMT_I2S:        v = (q.slot != 4'h0);
      FMT_LJ, FMT_RJ: v = (q.slot == 4'h0);
      FMT_PCM_L:      v = (q.slot == 4'h0) && (q.bitn < 5'h02);
      default:        v = (q.slot == 4'h0) && (q.bitn == 5'h00);
    endcase
    return v;
  endfunction

  // first and last data bit inside a slot
  function automatic logic [4:0] dat_lo(asp_frame_t f, logic rj);
    return rj ? 5'(f.last_bit - f.word_last) : 5'h00;
  endfunction

  function automatic logic [4:0] dat_hi(asp_frame_t f, logic rj);
    return rj ? f.last_bit : f.word_last;
  endfunction

endpackage

/* rtl/asp_sync.sv */
`timescale 1ns/1ns
// three stage synchroniser; output moves only when stages two and three agree
module asp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1 feeds s2 only, so a metastable first stage never reaches logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o  <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
    end
  end

endmodule

/* rtl/asp_word_cdc.sv */
`timescale 1ns/1ns
// one word toggle handshake between two clocks, valid/ready on both sides
module asp_word_cdc (
  input  wire logic        s_clk_i,
  input  wire logic        s_rst_i,
  input  wire logic        s_valid_i,
  input  wire logic [31:0] s_data_i,
  output logic             s_ready_o,
  input  wire logic        d_clk_i,
  input  wire logic        d_rst_i,
  output logic             d_valid_o,
  output logic      [31:0] d_data_o,
  input  wire logic        d_ready_i
);

  logic        req_r;
  logic [31:0] hold_r;
  logic        ack_r;
  logic        seen_r;
  logic        ack_q;
  logic        req_q;

  asp_sync #(.W(1)) u_ack (.clk_i(s_clk_i), .rst_i(s_rst_i), .d_i(ack_r), .q_o(ack_q));
  asp_sync #(.W(1)) u_req (.clk_i(d_clk_i), .rst_i(d_rst_i), .d_i(req_r), .q_o(req_q));

  wire s_acc = s_valid_i & s_ready_o;
  wire d_new = (req_q != seen_r) & ~d_valid_o;

  // source: hold the word steady until the far side hands the toggle back
  always_ff @(posedge s_clk_i) begin
    if (s_rst_i) begin
      req_r     <= 1'b0;
      hold_r    <= 32'h0000_0000;
      s_ready_o <= 1'b0;
    end else begin
      req_r     <= req_r ^ s_acc;
      hold_r    <= s_acc ? s_data_i : hold_r;
      s_ready_o <= ~s_acc & (ack_q == req_r);
    end
  end

  // destination: copy the word, offer it, acknowledge once taken
  always_ff @(posedge d_clk_i) begin
    if (d_rst_i) begin
      seen_r    <= 1'b0;
      ack_r     <= 1'b0;
      d_valid_o <= 1'b0;
      d_data_o  <= 32'h0000_0000;
    end else begin
      seen_r    <= d_new ? req_q : seen_r;
      d_data_o  <= d_new ? hold_r : d_data_o;
      d_valid_o <= d_new | (d_valid_o & ~d_ready_i);
      ack_r     <= (d_valid_o & d_ready_i) ? seen_r : ack_r;
    end
  end

endmodule

/* rtl/asp_top.sv */
`timescale 1ns/1ns
module asp_top import asp_pkg::*; (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        tx_valid_i,
  input  wire logic [31:0] tx_data_i,
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic      [31:0] rx_data_o,
  input  wire logic        rx_ready_i,
  input  wire logic        bclk_i,
  input  wire logic        fsync_i,
  output logic             fsync_o,
  output logic             fsync_oe_n_o,
  input  wire logic        sdin_i,
  output logic             sdout_o,
  output logic             sdout_oe_n_o
);

  // ---------------- device clock side ----------------
  asp_ctrl_t   ctrl_r;
  asp_frame_t  frm_r;
  logic [15:0] txm_r;
  logic [15:0] rxm_r;
  logic        udr_r;
  logic        ovr_r;
  logic        rate_r;
  logic [3:0]  msync;
  logic [3:0]  mprev_r;
  logic [7:0]  per_r;
  logic        seen_r;

  // ---------------- link clock side ----------------
  asp_lstate_t state_r;
  asp_lstate_t state_nxt;
  asp_ctrl_t   cfg_r;
  asp_frame_t  frm_l_r;
  logic [15:0] txm_l_r;
  logic [15:0] rxm_l_r;
  asp_pos_t    pos_r;
  logic [31:0] tsh_r;
  logic [31:0] rsh_r;
  logic        fs_s_r;
  logic        udr_t_r;
  logic        ovr_t_r;
  logic        act_l_r;
  logic [1:0]  lsync;
  logic        tdv;
  logic [31:0] tdata;
  logic        rsrdy;

  // register decode
  wire sel_ctrl = (reg_addr_i == ADR_CTRL);
  wire sel_frm  = (reg_addr_i == ADR_FRAME);
  wire sel_txm  = (reg_addr_i == ADR_TXMASK);
  wire sel_rxm  = (reg_addr_i == ADR_RXMASK);
  wire sel_stat = (reg_addr_i == ADR_STATUS);
  wire clr_stat = reg_wr_i & sel_stat;

  // unmapped offsets read as zero
  wire [31:0] rd_mux =
    sel_ctrl ? 32'(ctrl_r) :
    sel_frm  ? 32'(frm_r) :
    sel_txm  ? {16'h0000, txm_r} :
    sel_rxm  ? {16'h0000, rxm_r} :
    sel_stat ? {28'h000_0000, msync[3], rate_r, ovr_r, udr_r} :
               32'h0000_0000;

  // configuration registers; software changes them only while disabled
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
      frm_r  <= FRAME_RST;
      txm_r  <= MASK_RST;
      rxm_r  <= MASK_RST;
    end else if (reg_wr_i) begin
      ctrl_r <= sel_ctrl ? asp_ctrl_t'(reg_wdata_i[$bits(asp_ctrl_t)-1:0]) : ctrl_r;
      frm_r  <= sel_frm ? asp_frame_t'(reg_wdata_i[$bits(asp_frame_t)-1:0]) : frm_r;
      txm_r  <= sel_txm ? reg_wdata_i[15:0] : txm_r;
      rxm_r  <= sel_rxm ? reg_wdata_i[15:0] : rxm_r;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // link events and bit clock brought over into the device clock
  asp_sync #(.W(4)) u_to_m (
    .clk_i (mclk_i),
    .rst_i (reset_i),
    .d_i   ({act_l_r, ovr_t_r, udr_t_r, bclk_i}),
    .q_o   (msync)
  );

  wire       bclk_rise = msync[0] & ~mprev_r[0];
  wire       udr_ev    = msync[1] ^ mprev_r[1];
  wire       ovr_ev    = msync[2] ^ mprev_r[2];
  wire [7:0] min_cyc   = is_i2s(ctrl_r.fmt) ? I2S_MIN_CYC : TDM_MIN_CYC;
  // a bit clock period shorter than the limit marks a rate fault
  wire       rate_ev   = ctrl_r.en & bclk_rise & seen_r & (per_r < min_cyc);

  // bit clock period monitor; one device clock of jitter from sampling
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mprev_r <= 4'h0;
      per_r   <= 8'h00;
      seen_r  <= 1'b0;
    end else begin
      mprev_r <= msync;
      per_r   <= bclk_rise ? 8'h01 : ((per_r == PER_SAT) ? per_r : 8'(per_r + 8'h01));
      seen_r  <= ctrl_r.en & (seen_r | bclk_rise);
    end
  end

  // sticky status: an event in the clearing cycle wins over the clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      udr_r  <= 1'b0;
      ovr_r  <= 1'b0;
      rate_r <= 1'b0;
    end else begin
      udr_r  <= udr_ev | (udr_r & ~(clr_stat & reg_wdata_i[ST_UDR]));
      ovr_r  <= ovr_ev | (ovr_r & ~(clr_stat & reg_wdata_i[ST_OVR]));
      rate_r <= rate_ev | (rate_r & ~(clr_stat & reg_wdata_i[ST_RATE]));
    end
  end

  // ---------------- link clock domain ----------------
  asp_sync #(.W(2)) u_to_l (
    .clk_i (bclk_i),
    .rst_i (1'b0),
    .d_i   ({reset_i, ctrl_r.en}),
    .q_o   (lsync)
  );

  wire lrst = lsync[1];
  wire len  = lsync[0];

  // frame position decode
  wire asp_pos_t pos_last = {frm_l_r.last_slot, frm_l_r.last_bit};
  wire           dly      = is_delayed(cfg_r.fmt);
  wire           rj       = (cfg_r.fmt == FMT_RJ);
  wire [4:0]     d_lo     = dat_lo(frm_l_r, rj);
  wire [4:0]     d_hi     = dat_hi(frm_l_r, rj);
  // target: frame start seen on the partner's sync edge (I2S left = low)
  wire fs_det = ~cfg_r.init & ((cfg_r.fmt == FMT_I2S) ? (fs_s_r & ~fsync_i)
                                                      : (~fs_s_r & fsync_i));
  // p_cur is the bit ending at this edge, p_nxt the bit being launched
  wire asp_pos_t p_cur = fs_det ? (dly ? pos_last : POS_ZERO) : pos_r;
  wire asp_pos_t p_nxt = pos_adv(p_cur, frm_l_r);
  // delayed formats lead the data by one bit with their sync
  wire asp_pos_t p_fs  = dly ? pos_adv(p_nxt, frm_l_r) : p_nxt;
  wire           act_n = (state_nxt == L_RUN);
  wire           act_c = (state_r == L_RUN);

  // half duplex lets transmit win the line
  wire tx_on = cfg_r.tx_en;
  wire rx_on = cfg_r.rx_en & (cfg_r.fdx | ~cfg_r.tx_en);

  // transmit decode for the bit being launched
  wire        tx_slot = act_n & tx_on & txm_l_r[p_nxt.slot];
  wire        tx_bit  = tx_slot & (p_nxt.bitn >= d_lo) & (p_nxt.bitn <= d_hi);
  wire        tx_take = tx_bit & (p_nxt.bitn == d_lo);
  wire [31:0] tx_load = tdv ? (tdata << 5'(5'd31 - frm_l_r.word_last)) : 32'h0000_0000;
  wire [31:0] tx_word = tx_take ? tx_load : tsh_r;

  // receive decode for the bit just sampled
  wire        rx_bit  = act_c & rx_on & rxm_l_r[p_cur.slot] &
                        (p_cur.bitn >= d_lo) & (p_cur.bitn <= d_hi);
  wire        rx_push = rx_bit & (p_cur.bitn == d_hi);
  wire [31:0] rx_word = (p_cur.bitn == d_lo) ? {31'h0000_0000, sdin_i}
                                             : {rsh_r[30:0], sdin_i};

  // link state: initiator starts at once, target hunts for frame sync
  always_comb begin
    case (state_r)
      L_IDLE:  state_nxt = ~len ? L_IDLE : (cfg_r.init ? L_RUN : L_HUNT);
      L_HUNT:  state_nxt = ~len ? L_IDLE : (fs_det ? L_RUN : L_HUNT);
      L_RUN:   state_nxt = len ? L_RUN : L_IDLE;
      default: state_nxt = L_IDLE;
    endcase
  end

  // configuration is frozen while the link runs, so it is stable when read
  always_ff @(posedge bclk_i) begin
    if (lrst) begin
      cfg_r   <= CTRL_RST;
      frm_l_r <= FRAME_RST;
      txm_l_r <= MASK_RST;
      rxm_l_r <= MASK_RST;
    end else if (state_r == L_IDLE) begin
      cfg_r   <= ctrl_r;
      frm_l_r <= frm_r;
      txm_l_r <= txm_r;
      rxm_l_r <= rxm_r;
    end
  end

  // frame counters; target re-aligns on every detected sync edge
  always_ff @(posedge bclk_i) begin
    if (lrst) begin
      state_r <= L_IDLE;
      pos_r   <= POS_ZERO;
      fs_s_r  <= 1'b0;
      act_l_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r   <= act_n ? p_nxt : pos_last;
      fs_s_r  <= fsync_i;
      act_l_r <= act_n;
    end
  end

  // pins: sync driven only as initiator; data floats outside used slots
  always_ff @(posedge bclk_i) begin
    if (lrst) begin
      fsync_o      <= 1'b0;
      fsync_oe_n_o <= 1'b1;
      sdout_o      <= 1'b0;
      sdout_oe_n_o <= 1'b1;
    end else begin
      fsync_o      <= act_n & cfg_r.init & fs_level(cfg_r.fmt, p_fs);
      fsync_oe_n_o <= ~(cfg_r.init & len);
      sdout_o      <= tx_bit & tx_word[31];
      sdout_oe_n_o <= ~(tx_slot | (act_n & tx_on & ~cfg_r.hiz));
    end
  end

  // shifters; a missing word sends zeros and a full queue drops one word
  always_ff @(posedge bclk_i) begin
    if (lrst) begin
      tsh_r   <= 32'h0000_0000;
      rsh_r   <= 32'h0000_0000;
      udr_t_r <= 1'b0;
      ovr_t_r <= 1'b0;
    end else begin
      tsh_r   <= tx_word << 1;
      rsh_r   <= rx_bit ? rx_word : rsh_r;
      udr_t_r <= udr_t_r ^ (tx_take & ~tdv);
      ovr_t_r <= ovr_t_r ^ (rx_push & ~rsrdy);
    end
  end

  // memory to link: source stalls on tx_ready_o while a word is in flight
  asp_word_cdc u_txq (
    .s_clk_i   (mclk_i),
    .s_rst_i   (reset_i),
    .s_valid_i (tx_valid_i),
    .s_data_i  (tx_data_i),
    .s_ready_o (tx_ready_o),
    .d_clk_i   (bclk_i),
    .d_rst_i   (lrst),
    .d_valid_o (tdv),
    .d_data_o  (tdata),
    .d_ready_i (tx_take)
  );

  // link to memory: word held on rx_valid_o until rx_ready_i
  asp_word_cdc u_rxq (
    .s_clk_i   (bclk_i),
    .s_rst_i   (lrst),
    .s_valid_i (rx_push),
    .s_data_i  (rx_word),
    .s_ready_o (rsrdy),
    .d_clk_i   (mclk_i),
    .d_rst_i   (reset_i),
    .d_valid_o (rx_valid_o),
    .d_data_o  (rx_data_o),
    .d_ready_i (rx_ready_i)
  );

  // ---------------- checks ----------------
  a_pcm_short_fs: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (cfg_r.init && cfg_r.fmt == FMT_PCM_S && $rose(fsync_o)) |=> !fsync_o
  ) else $error("short sync not one bit clock wide");

  a_pcm_long_fs: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (cfg_r.init && cfg_r.fmt == FMT_PCM_L && act_l_r && $rose(fsync_o))
      |=> fsync_o ##1 !fsync_o
  ) else $error("long sync not two bit clocks wide");

  a_i2s_ws_lead: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (cfg_r.init && cfg_r.fmt == FMT_I2S && $fell(fsync_o)) |-> pos_r == pos_last
  ) else $error("word select not one bit ahead of left data");

  a_hiz_unused_slot: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (act_n && cfg_r.hiz && !txm_l_r[p_nxt.slot]) |=> sdout_oe_n_o
  ) else $error("data driven in an unused slot");

  a_tx_slot_drive: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (act_l_r && cfg_r.hiz && !sdout_oe_n_o) |-> txm_l_r[pos_r.slot] && cfg_r.tx_en
  ) else $error("data driven outside transmit slots");

  a_half_duplex: assert property (
    @(posedge bclk_i) disable iff (lrst)
    (!cfg_r.fdx && cfg_r.tx_en) |-> !rx_push
  ) else $error("receive active in half duplex transmit");

  a_rx_slot_sel: assert property (
    @(posedge bclk_i) disable iff (lrst)
    rx_push |-> act_c && rxm_l_r[p_cur.slot] && p_cur.bitn == d_hi
  ) else $error("word completed outside a receive slot");

  a_rate_i2s: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (ctrl_r.en && is_i2s(ctrl_r.fmt) && bclk_rise && seen_r && per_r < I2S_MIN_CYC)
      |=> rate_r
  ) else $error("fast I2S bit clock not flagged");

  a_rate_tdm: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (ctrl_r.en && !is_i2s(ctrl_r.fmt) && bclk_rise && seen_r && per_r < TDM_MIN_CYC)
      |=> rate_r
  ) else $error("fast TDM bit clock not flagged");

  a_tx_ready_stall: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (tx_valid_i && tx_ready_o) |=> !tx_ready_o [*2]
  ) else $error("transmit queue took a second word too early");

  a_rx_hold_word: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (rx_valid_o && !rx_ready_i) |=> rx_valid_o && $stable(rx_data_o)
  ) else $error("receive word dropped while stalled");

  a_udr_sticky: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (udr_r && !(clr_stat && reg_wdata_i[ST_UDR])) |=> udr_r
  ) else $error("underrun flag lost without clear");

  c_i2s_frame: cover property (
    @(posedge bclk_i) disable iff (lrst) cfg_r.fmt == FMT_I2S && $fell(fsync_o));
  c_rx_word: cover property (
    @(posedge bclk_i) disable iff (lrst) rx_push && rsrdy);
  c_tx_underrun: cover property (
    @(posedge bclk_i) disable iff (lrst) tx_take && !tdv);
  c_target_lock: cover property (
    @(posedge bclk_i) disable iff (lrst) state_r == L_HUNT && fs_det);

endmodule

/* verification/asp_codec_model.sv */
`timescale 1ns/1ns
// behavioural codec on the far side of the serial link
module asp_codec_model (
  input  wire logic        fast_i,
  input  wire logic        lead_i,
  input  wire logic        fs_line_i,
  input  wire logic        sd_line_i,
  input  wire logic [23:0] word_i,
  output logic             bclk_o,
  output logic             fs_o,
  output logic             sdin_o,
  output logic      [23:0] cap_o
);
  logic [5:0]  fc_r;
  logic [5:0]  pos_r;
  logic [23:0] sh_r;

  initial begin
    bclk_o = 1'b0;
    fs_o   = 1'b0;
    sdin_o = 1'b0;
    fc_r   = 6'h00;
    pos_r  = 6'h3f;
    sh_r   = 24'h00_0000;
    cap_o  = 24'h00_0000;
  end

  // bit clock never stops, the device needs it even through reset;
  // fast mode is 42 ns, inside the PCM limit but above the I2S one
  always #(fast_i ? 21 : 40) bclk_o = ~bclk_o;

  // track the frame from whatever sync is on the wire; grab slot 0 data
  always @(posedge bclk_o) begin
    pos_r <= fs_line_i ? 6'h00 : 6'(pos_r + 6'h01);
    if (pos_r < 6'h18) sh_r <= {sh_r[22:0], sd_line_i};
    if (pos_r == 6'h18) cap_o <= sh_r;
  end

  // one sync pulse every 64 bits when leading; data msb first in both slots,
  // slot 1 inverted so a wrong slot choice is visible; toggles between words
  always @(negedge bclk_o) begin
    fc_r   <= 6'(fc_r + 6'h01);
    fs_o   <= lead_i && (fc_r == 6'h3e);
    sdin_o <= (pos_r[4:0] < 5'h18) ? (word_i[5'(5'h17 - pos_r[4:0])] ^ pos_r[5]) : ~sdin_o;
  end
endmodule

/* verification/test_audio_serial_port_tdm.sv */
`timescale 1ns/1ns
module test_audio_serial_port_tdm import asp_pkg::*; ;
  typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } asp_row_t;
  logic        mclk_i      = 1'b0;
  logic        reset_i     = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        tx_valid_i  = 1'b0;
  logic [31:0] tx_data_i   = 32'h00a5_c396;
  logic        rx_ready_i  = 1'b0;
  logic        lead        = 1'b0;
  logic        fast        = 1'b0;
  logic [31:0] reg_rdata_o, rx_data_o, rd_v;
  logic        tx_ready_o, rx_valid_o, fsync_o, fsync_oe_n_o, sdout_o, sdout_oe_n_o;
  logic        bclk, fs_gen, sdin;
  logic [23:0] cap;
  int          err_count   = 0;
  int          n_tests     = 0;
  int          fs_n, oe_n;
  asp_row_t    rows [15];
  asp_fmt_t    fmts [7];
  int          fsx  [7];
  // wire levels from both parties' enables
  wire         fs_line = fsync_oe_n_o ? (lead ? fs_gen : 1'b0) : fsync_o;
  // a released data line shows the inverse, so late sampling is visible
  wire         sd_line = sdout_oe_n_o ? ~sdout_o : sdout_o;

  asp_top u_dut (.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
    .rx_ready_i, .bclk_i(bclk), .fsync_i(fs_line), .fsync_o, .fsync_oe_n_o,
    .sdin_i(sdin), .sdout_o, .sdout_oe_n_o);

  asp_codec_model u_codec (.fast_i(fast), .lead_i(lead), .fs_line_i(fs_line),
    .sd_line_i(sd_line), .word_i(24'h3c_5ae1), .bclk_o(bclk), .fs_o(fs_gen),
    .sdin_o(sdin), .cap_o(cap));

  always #4 mclk_i = ~mclk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask

  task automatic bclks(input int n);
    repeat (n) @(posedge bclk);
  endtask

  function automatic logic [31:0] cfg(asp_fmt_t f, logic ini, logic tx, logic rx, logic fd);
    asp_ctrl_t c;
    c = '{fmt: f, hiz: 1'b1, fdx: fd, rx_en: rx, tx_en: tx, init: ini, en: 1'b1};
    return {23'h00_0000, c};
  endfunction

  // config only moves while disabled; memory side drains meanwhile so the
  // next held word comes from a whole frame, not the partial first one
  // the disable must last several link clocks or the link never sees it
  task automatic start(input logic [31:0] c);
    reg_wr(ADR_CTRL, 32'h0000_0000);
    rx_ready_i <= 1'b1;
    bclks(8);
    reg_wr(ADR_CTRL, c);
    bclks(200);
    @(posedge mclk_i);
    rx_ready_i <= 1'b0;
  endtask

  task automatic wait_rx();
    int k;
    for (k = 0; k < 4000 && rx_valid_o !== 1'b1; k++) @(negedge mclk_i);
    if (k == 4000) begin
      err_count++;
      wrap_up();
    end
  endtask

  // withdraw the transmit source only on an edge at which a word is taken
  task automatic tx_stop();
    int k;
    for (k = 0; k < 2000 && tx_ready_o !== 1'b1; k++) @(negedge mclk_i);
    if (k == 2000) begin
      err_count++;
      wrap_up();
    end
    @(posedge mclk_i);
    tx_valid_i <= 1'b0;
  endtask

  // one frame of 64 bits: sync high bits and driven data bits
  task automatic meas();
    fs_n = 0;
    oe_n = 0;
    repeat (64) begin
      @(negedge bclk);
      fs_n += int'(fsync_o === 1'b1);
      oe_n += int'(sdout_oe_n_o === 1'b0);
    end
  endtask

  initial begin
    rows = '{{1'b0, ADR_CTRL, 32'h0000_0000}, {1'b0, ADR_FRAME, 32'h0000_2ff1},
      {1'b0, ADR_TXMASK, 32'h0000_0003}, {1'b0, ADR_RXMASK, 32'h0000_0003},
      {1'b0, ADR_STATUS, 32'h0000_0000}, {1'b0, 8'h14, 32'h0000_0000},
      {1'b1, ADR_TXMASK, 32'h0000_0005}, {1'b0, ADR_TXMASK, 32'h0000_0005},
      {1'b1, 8'h14, 32'hffff_ffff}, {1'b0, 8'h14, 32'h0000_0000},
      {1'b1, ADR_TXMASK, 32'h0001_0003}, {1'b0, ADR_TXMASK, 32'h0000_0003},
      {1'b1, ADR_TXMASK, 32'h0000_0001}, {1'b1, ADR_RXMASK, 32'h0000_0002},
      {1'b0, ADR_RXMASK, 32'h0000_0002}};
    fmts = '{FMT_I2S, FMT_LJ, FMT_RJ, FMT_DSP, FMT_PCM_S, FMT_PCM_L, FMT_TDM};
    fsx = '{32, 32, 32, 1, 1, 2, 1};
    // reset must span several link clocks to reach the link side
    bclks(6);
    @(posedge mclk_i);
    check({reg_rdata_o[29:0], tx_ready_o, rx_valid_o}, 32'h0000_0000);
    reset_i <= 1'b0;
    bclks(8);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        reg_wr(rows[i].a, rows[i].d);
      end else begin
        reg_rd(rows[i].a, rd_v);
        check(rd_v, rows[i].d);
      end
    end
    // every framing, initiator, transmit slot 0 only
    foreach (fmts[i]) begin
      start(cfg(fmts[i], 1'b1, 1'b1, 1'b0, 1'b0));
      meas();
      check(32'(fs_n), 32'(fsx[i]));
      check(32'(oe_n), 32'h0000_0020);
    end
    // full duplex, then a stalled memory side
    @(posedge mclk_i);
    tx_valid_i <= 1'b1;
    start(cfg(FMT_PCM_S, 1'b1, 1'b1, 1'b1, 1'b1));
    wait_rx();
    check(rx_data_o, 32'h00c3_a51e);
    check({8'h00, cap}, 32'h00a5_c396);
    bclks(200);
    check(rx_data_o, 32'h00c3_a51e);
    reg_rd(ADR_STATUS, rd_v);
    check(rd_v & 32'h0000_0002, 32'h0000_0002);
    // half duplex: transmit wins, nothing received
    start(cfg(FMT_PCM_S, 1'b1, 1'b1, 1'b1, 1'b0));
    reg_wr(ADR_STATUS, 32'h0000_0001);
    bclks(130);
    check({31'h0000_0000, rx_valid_o}, 32'h0000_0000);
    reg_rd(ADR_STATUS, rd_v);
    check(rd_v & 32'h0000_0001, 32'h0000_0000);
    // source dries up: the link sends zeros and flags the underrun
    tx_stop();
    bclks(260);
    reg_rd(ADR_STATUS, rd_v);
    check(rd_v & 32'h0000_0001, 32'h0000_0001);
    // target role, codec leads the frame
    @(posedge mclk_i);
    lead <= 1'b1;
    start(cfg(FMT_PCM_S, 1'b0, 1'b0, 1'b1, 1'b0));
    check({31'h0000_0000, fsync_oe_n_o}, 32'h0000_0001);
    wait_rx();
    check(rx_data_o, 32'h00c3_a51e);
    // 42 ns bit clock: too fast for the I2S family, legal for PCM
    @(posedge mclk_i);
    fast <= 1'b1;
    lead <= 1'b0;
    start(cfg(FMT_I2S, 1'b1, 1'b1, 1'b0, 1'b0));
    reg_rd(ADR_STATUS, rd_v);
    check(rd_v & 32'h0000_0004, 32'h0000_0004);
    start(cfg(FMT_PCM_S, 1'b1, 1'b1, 1'b0, 1'b0));
    reg_wr(ADR_STATUS, 32'h0000_0004);
    bclks(100);
    reg_rd(ADR_STATUS, rd_v);
    check(rd_v & 32'h0000_0004, 32'h0000_0000);
    wrap_up();
  end
endmodule
